// [rtl/ctb_bank.sv]
/*
  calibration and trim register bank: calibration vector access port
  with enable and sequence tracking, gain, reference, termination and
  timing-adjust trims.
  assumes a register port master that keeps strobes one cycle long and
  never asserts both at once; factory values arrive on fuse_* inputs
  from a fuse block on the same clock, stable around reset release.
*/
// The implementer's own choice: the plain strobed port.
`timescale 1ns/100ps
module ctb_bank
  import ctb_pkg::*;
#(
  parameter int VEC_DEPTH = ctb_pkg::VEC_LEN
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [ctb_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ctb_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [ctb_pkg::DATA_W-1:0] reg_rdata,
  input wire logic cal_halted_flag,
  input wire logic [7:0] fuse_gain_a,
  input wire logic [7:0] fuse_gain_b,
  input wire logic [3:0] fuse_ref,
  input wire logic [7:0] fuse_term_a,
  input wire logic [7:0] fuse_term_b,
  input wire logic [23:0] fuse_skew,
  output logic [7:0] gain_adjust_chan_a,
  output logic [7:0] gain_adjust_chan_b,
  output logic [3:0] reference_voltage_adjust,
  output logic [7:0] termination_adjust_input_a,
  output logic [7:0] termination_adjust_input_b,
  output logic [23:0] core_skew,
  output logic cal_vec_valid,
  output logic cal_corrupt
);
  import ctb_pkg::*;

  initial begin
    if (VEC_DEPTH < 2 || VEC_DEPTH > (1 << IDX_W))
      $error("ctb_bank: unsupported vector depth");
  end

  typedef struct packed {
    logic [7:0] cal_en;
    logic [IDX_W-1:0] idx;
    logic valid;
    logic corrupt;
    logic busy;
    logic load;
    logic rd_port;
    logic [7:0] rdata;
    logic [7:0] gain_a;
    logic [7:0] gain_b;
    logic [3:0] refv;
    logic [7:0] term_a;
    logic [7:0] term_b;
    logic [23:0] skew;
  } ctb_state_t;

  ctb_state_t st;
  ctb_state_t next_st;
  logic port_hit;
  logic port_go;
  logic mem_wr;
  logic mem_rd;
  logic [7:0] mem_q;

  // address freeze is a property of the serial front end: a streamed
  // burst simply arrives here as repeated accesses to the port offset
  assign port_hit = (reg_addr == OFS_CAL_PORT) && (reg_wr || reg_rd);
  assign port_go = port_hit && st.cal_en[EN_BIT];
  assign mem_wr = port_go && reg_wr;
  assign mem_rd = port_go && reg_rd;

  ctb_vec_mem #(
    .DEPTH(VEC_DEPTH),
    .AW(IDX_W),
    .DW(DATA_W)
  ) u_mem (
    .core_clk(core_clk),
    .wr_en(mem_wr),
    .rd_en(mem_rd),
    .addr(st.idx),
    .wr_data(reg_wdata),
    .rd_data(mem_q)
  );

  always_comb begin
    next_st = st;
    next_st.load = 1'b0;
    next_st.rd_port = 1'b0;
    if (st.load) begin
      // factory values taken one cycle after release, never under reset
      next_st.gain_a = fuse_gain_a;
      next_st.gain_b = fuse_gain_b;
      next_st.refv = fuse_ref;
      next_st.term_a = fuse_term_a;
      next_st.term_b = fuse_term_b;
      next_st.skew = fuse_skew;
    end
    if (port_go) begin
      if (!cal_halted_flag) begin
        next_st.corrupt = 1'b1;
      end
      if (!st.busy) begin
        next_st.busy = 1'b1;
        next_st.valid = 1'b0;
      end
      if (st.idx == IDX_W'(VEC_DEPTH - 1)) begin
        next_st.idx = IDX_RST;
        next_st.busy = 1'b0;
        next_st.valid = 1'b1;
      end else begin
        next_st.idx = st.idx + 1'b1;
      end
    end
    if (reg_wr) begin
      unique case (reg_addr)
        OFS_CAL_EN: begin
          next_st.cal_en = reg_wdata;
          if (!reg_wdata[EN_BIT]) begin
            next_st.idx = IDX_RST;
            if (st.busy) begin
              next_st.busy = 1'b0;
              next_st.valid = 1'b0;
            end
          end
        end
        OFS_GAIN_A: next_st.gain_a = reg_wdata;
        OFS_GAIN_B: next_st.gain_b = reg_wdata;
        OFS_REF: next_st.refv = reg_wdata[REF_W-1:0];
        OFS_TERM_A: next_st.term_a = reg_wdata;
        OFS_TERM_B: next_st.term_b = reg_wdata;
        OFS_SKEW_A_FGQ: next_st.skew[7:0] = reg_wdata;
        OFS_SKEW_B_FGI: next_st.skew[15:8] = reg_wdata;
        OFS_SKEW_A_BGI: next_st.skew[23:16] = reg_wdata;
        OFS_STATUS: begin
          if (reg_wdata[1]) begin
            next_st.corrupt = 1'b0;
          end
        end
        default: ;
      endcase
    end
    next_st.rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_CAL_EN: next_st.rdata = st.cal_en;
        OFS_CAL_PORT: next_st.rd_port = st.cal_en[EN_BIT];
        OFS_GAIN_A: next_st.rdata = st.gain_a;
        OFS_GAIN_B: next_st.rdata = st.gain_b;
        OFS_REF: next_st.rdata = {4'h0, st.refv};
        OFS_TERM_A: next_st.rdata = st.term_a;
        OFS_TERM_B: next_st.rdata = st.term_b;
        OFS_SKEW_A_FGQ: next_st.rdata = st.skew[7:0];
        OFS_SKEW_B_FGI: next_st.rdata = st.skew[15:8];
        OFS_SKEW_A_BGI: next_st.rdata = st.skew[23:16];
        OFS_STATUS: next_st.rdata = {5'h00, st.busy, st.corrupt, st.valid};
        default: next_st.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st <= '0;
      st.cal_en <= CAL_EN_RST;
      st.idx <= IDX_RST;
      st.load <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // port read data comes from the memory register, so merge it here
  assign reg_rdata = st.rd_port ? mem_q : st.rdata;
  assign gain_adjust_chan_a = st.gain_a;
  assign gain_adjust_chan_b = st.gain_b;
  assign reference_voltage_adjust = st.refv;
  assign termination_adjust_input_a = st.term_a;
  assign termination_adjust_input_b = st.term_b;
  assign core_skew = st.skew;
  assign cal_vec_valid = st.valid;
  assign cal_corrupt = st.corrupt;

  // helper: previous-cycle port read strobe while disabled, for the read data check
  logic prev_rd_dis;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      prev_rd_dis <= 1'b0;
    end else begin
      prev_rd_dis <= reg_rd && reg_addr == OFS_CAL_PORT
        && !st.cal_en[EN_BIT];
    end
  end

  enable_gate_a: assert property (@(posedge core_clk) disable iff (rst)
    !st.cal_en[EN_BIT] |-> !mem_wr && !mem_rd)
    else $error("port active while disabled");
  idx_advance_a: assert property (@(posedge core_clk) disable iff (rst)
    port_go && reg_wr == 1'b0 && st.idx != IDX_W'(VEC_DEPTH - 1)
      && !(reg_wr && reg_addr == OFS_CAL_EN)
      |=> st.idx == $past(st.idx) + 1'b1)
    else $error("index did not advance");
  wrap_valid_a: assert property (@(posedge core_clk) disable iff (rst)
    port_go && st.idx == IDX_W'(VEC_DEPTH - 1)
      |=> st.valid && st.idx == '0 && !st.busy)
    else $error("full sequence not marked valid");
  stream_hit_a: assert property (@(posedge core_clk) disable iff (rst)
    reg_wr && reg_addr == OFS_CAL_PORT && st.cal_en[EN_BIT] |-> mem_wr)
    else $error("streamed write missed port");
  halt_check_a: assert property (@(posedge core_clk) disable iff (rst)
    port_go && !cal_halted_flag |=> st.corrupt)
    else $error("corruption not flagged");
  abandon_inv_a: assert property (@(posedge core_clk) disable iff (rst)
    st.busy && reg_wr && reg_addr == OFS_CAL_EN && !reg_wdata[EN_BIT]
      |=> !st.valid && !st.busy)
    else $error("abandoned sequence left valid");
  ref_resv_a: assert property (@(posedge core_clk) disable iff (rst)
    reg_rd && reg_addr == OFS_REF |=> reg_rdata[7:4] == 4'h0)
    else $error("reserved reference bits nonzero");
  gain_wr_a: assert property (@(posedge core_clk) disable iff (rst)
    reg_wr && reg_addr == OFS_GAIN_A |=> gain_adjust_chan_a == $past(reg_wdata))
    else $error("gain a not written");
  term_wr_a: assert property (@(posedge core_clk) disable iff (rst)
    reg_wr && reg_addr == OFS_TERM_B
      |=> termination_adjust_input_b == $past(reg_wdata))
    else $error("termination b not written");
  fuse_load_a: assert property (@(posedge core_clk)
    $fell(rst) |=> gain_adjust_chan_b == $past(fuse_gain_b))
    else $error("factory value not loaded");
  en_reset_a: assert property (@(posedge core_clk)
    rst |=> st.cal_en == CAL_EN_RST && st.idx == IDX_RST)
    else $error("enable register reset wrong");
  idx_clear_a: assert property (@(posedge core_clk) disable iff (rst)
    !st.cal_en[EN_BIT] |-> st.idx == IDX_RST)
    else $error("index not cleared");
  dis_read_a: assert property (@(posedge core_clk) disable iff (rst)
    prev_rd_dis |-> reg_rdata == 8'h00)
    else $error("disabled port read nonzero");
  skew_wr_a: assert property (@(posedge core_clk) disable iff (rst)
    reg_wr && reg_addr == OFS_SKEW_B_FGI |=> core_skew[15:8] == $past(reg_wdata))
    else $error("skew not written");
  term_a_wr_a: assert property (@(posedge core_clk) disable iff (rst)
    reg_wr && reg_addr == OFS_TERM_A
      |=> termination_adjust_input_a == $past(reg_wdata))
    else $error("termination a not written");

  seq_done_c: cover property (@(posedge core_clk) disable iff (rst)
    $rose(st.valid));
  corrupt_c: cover property (@(posedge core_clk) disable iff (rst)
    $rose(st.corrupt));
  abandon_c: cover property (@(posedge core_clk) disable iff (rst)
    $fell(st.busy) && !st.valid);
endmodule

// [rtl/ctb_pkg.sv]
/*
  constants for the calibration and trim register bank: register offsets,
  reset values, field positions and the calibration vector length.
  assumes an 8-bit register port with 12-bit addresses.
*/
// Contract
// - vector port works only with enable bit 0
// - each port read returns next vector value
// - address freeze keeps streaming on port
// - port access while calibrating corrupts calibration
// - sequence cut short leaves data invalid
// - eight-bit gain trim per channel
// - reference trim bits 3-0, 7-4 reserved zero
// - eight-bit termination trim for input a
// - eight-bit termination trim for input b
// - eight-bit timing adjust per converter core
// - trims load factory values after reset
// - enable register at 0x070, resets 0x00
package ctb_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int VEC_LEN = 673;
  localparam int IDX_W = 10;
  localparam logic [11:0] OFS_CAL_EN = 12'h070;
  localparam logic [11:0] OFS_CAL_PORT = 12'h071;
  localparam logic [11:0] OFS_GAIN_A = 12'h07A;
  localparam logic [11:0] OFS_GAIN_B = 12'h07B;
  localparam logic [11:0] OFS_REF = 12'h07C;
  localparam logic [11:0] OFS_TERM_A = 12'h07E;
  localparam logic [11:0] OFS_TERM_B = 12'h07F;
  localparam logic [11:0] OFS_SKEW_A_FGQ = 12'h080;
  localparam logic [11:0] OFS_SKEW_B_FGI = 12'h081;
  localparam logic [11:0] OFS_SKEW_A_BGI = 12'h082;
  localparam logic [11:0] OFS_STATUS = 12'h0F0;
  localparam int EN_BIT = 0;
  localparam int REF_W = 4;
  localparam logic [7:0] CAL_EN_RST = 8'h00;
  localparam logic [9:0] IDX_RST = 10'h000;
endpackage

// [rtl/ctb_vec_mem.sv]
/*
  single-port memory holding the calibration vector, registered read data.
  assumes one access per cycle from the register bank.
*/
`timescale 1ns/100ps
module ctb_vec_mem #(
  parameter int DEPTH = 673,
  parameter int AW = 10,
  parameter int DW = 8
) (
  input wire logic core_clk,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wr_data,
  output logic [DW-1:0] rd_data
);
  logic [DW-1:0] mem [DEPTH];

  initial begin
    if (DEPTH > (1 << AW)) $error("ctb_vec_mem: depth exceeds address");
  end

  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data <= mem[addr];
    end
  end
endmodule

// [testbench/tb.sv]
/*
  self-checking bench for the calibration and trim register bank.
  assumes ctb_pkg and ctb_bank are compiled first; it drives the
  register port itself.
*/
`timescale 1ns/100ps
module tb;
  import ctb_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic cal_halted_flag = 1'b1;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] fuse_gain_a = 8'hA5;
  logic [7:0] fuse_gain_b = 8'h5A;
  logic [3:0] fuse_ref = 4'hC;
  logic [7:0] fuse_term_a = 8'h3C;
  logic [7:0] fuse_term_b = 8'hC3;
  logic [23:0] fuse_skew = 24'h96E10F;
  logic [7:0] reg_rdata, gain_a, gain_b, term_a, term_b;
  logic [3:0] ref_adj;
  logic [23:0] core_skew;
  logic cal_vec_valid, cal_corrupt;
  int fail_count = 0;
  int num_checks = 0;
  logic [11:0] offs [8];
  logic [7:0] vals [8];

  ctb_bank u_ctb_bank (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cal_halted_flag(cal_halted_flag),
    .fuse_gain_a(fuse_gain_a), .fuse_gain_b(fuse_gain_b),
    .fuse_ref(fuse_ref), .fuse_term_a(fuse_term_a),
    .fuse_term_b(fuse_term_b), .fuse_skew(fuse_skew),
    .gain_adjust_chan_a(gain_a), .gain_adjust_chan_b(gain_b),
    .reference_voltage_adjust(ref_adj),
    .termination_adjust_input_a(term_a),
    .termination_adjust_input_b(term_b), .core_skew(core_skew),
    .cal_vec_valid(cal_vec_valid), .cal_corrupt(cal_corrupt));

  initial begin
    forever #5 core_clk = ~core_clk;
  end

  function automatic logic [7:0] pat(input int i);
    return 8'(i * 37 + 5);
  endfunction

  task automatic close_out();
    if (fail_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask

  // back-to-back port writes, one byte per edge
  task automatic burst_wr(input int n);
    @(posedge core_clk);
    for (int i = 0; i < n; i++) begin
      reg_wr <= 1'b1;
      reg_addr <= OFS_CAL_PORT;
      reg_wdata <= pat(i);
      @(posedge core_clk);
    end
    reg_wr <= 1'b0;
    #1;
  endtask

  // back-to-back port reads; each byte is checked in the cycle it stands
  task automatic burst_rd(input int n);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= OFS_CAL_PORT;
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      if (i == n - 1) begin
        reg_rd <= 1'b0;
      end
      #1 chk(reg_rdata, pat(i));
    end
  endtask

  task automatic reset_values();
    chk(gain_a, fuse_gain_a);
    chk({4'h0, ref_adj}, {4'h0, fuse_ref});
    rd_chk(OFS_GAIN_B, fuse_gain_b);
    rd_chk(OFS_REF, {4'h0, fuse_ref});
    rd_chk(OFS_TERM_A, fuse_term_a);
    rd_chk(OFS_SKEW_A_BGI, fuse_skew[23:16]);
    rd_chk(OFS_CAL_EN, 8'h00);
    chk({7'h00, cal_vec_valid}, 8'h00);
  endtask

  task automatic trim_writes();
    offs = '{OFS_GAIN_A, OFS_GAIN_B, OFS_REF, OFS_TERM_A, OFS_TERM_B,
      OFS_SKEW_A_FGQ, OFS_SKEW_B_FGI, OFS_SKEW_A_BGI};
    for (int k = 0; k < 8; k++) begin
      vals[k] = 8'(8'h1E + k * 8'h35);
      wr(offs[k], vals[k]);
    end
    vals[2] = {4'h0, vals[2][3:0]};
    for (int k = 0; k < 8; k++) begin
      rd_chk(offs[k], vals[k]);
    end
    chk(gain_b, vals[1]);
    chk({4'h0, ref_adj}, vals[2]);
    chk(term_a, vals[3]);
    chk(term_b, vals[4]);
    chk(core_skew[15:8], vals[6]);
  endtask

  task automatic vector_save_restore();
    wr(OFS_CAL_EN, 8'h01);
    burst_wr(VEC_LEN);
    chk({7'h00, cal_vec_valid}, 8'h01);
    wr(OFS_CAL_EN, 8'h00);
    wr(OFS_CAL_PORT, 8'hEE);
    rd_chk(OFS_CAL_PORT, 8'h00);
    wr(OFS_CAL_EN, 8'h01);
    burst_rd(VEC_LEN);
    chk({7'h00, cal_vec_valid}, 8'h01);
    burst_rd(10);
    chk({7'h00, cal_vec_valid}, 8'h00);
    chk({7'h00, cal_corrupt}, 8'h00);
  endtask

  task automatic corrupt_and_unmapped();
    cal_halted_flag <= 1'b0;
    rd_chk(OFS_CAL_PORT, pat(10));
    chk({7'h00, cal_corrupt}, 8'h01);
    cal_halted_flag <= 1'b1;
    wr(OFS_STATUS, 8'h02);
    chk({7'h00, cal_corrupt}, 8'h00);
    rd_chk(12'h0FF, 8'h00);
    // abandon the open read sequence: index and busy must both clear
    wr(OFS_CAL_EN, 8'h00);
    rd_chk(OFS_STATUS, 8'h00);
    chk({7'h00, cal_vec_valid}, 8'h00);
    wr(OFS_CAL_EN, 8'h01);
    rd_chk(OFS_CAL_PORT, pat(0));
    wr(OFS_CAL_EN, 8'h00);
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    close_out();
  end

  initial begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    // trims reload from fuses on the first edge after release
    repeat (3) @(posedge core_clk);
    #1;
    reset_values();
    trim_writes();
    vector_save_restore();
    corrupt_and_unmapped();
    close_out();
  end
endmodule
